/* File: core/prtpm_pkg.sv */
/*
 * Constants, field layouts and carrier types of the prescaled pulse timer.
 * Assumes a 32-bit APB master with byte-wide registers in the low data lane.
 */
package prtpm_pkg;

	// --------------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// --------------------------------------------------------------------
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] IDX_CONTROL    = 12'h100;
	localparam logic [11:0] IDX_IO_CONTROL = 12'h101;
	localparam logic [11:0] IDX_MODE       = 12'h102;
	localparam logic [11:0] IDX_PRESCALER  = 12'h103;
	localparam logic [11:0] IDX_MAIN_COUNT = 12'h104;

	// --------------------------------------------------------------------
	// Control register bit positions
	// --------------------------------------------------------------------
	localparam int CTL_START_BIT  = 0;
	localparam int CTL_STATUS_BIT = 1;
	localparam int CTL_STOP_BIT   = 2;
	localparam int CTL_EDGE_BIT   = 4;
	localparam int CTL_UNDF_BIT   = 5;

	// --------------------------------------------------------------------
	// Reset values and timing counts
	// --------------------------------------------------------------------
	localparam logic [7:0] RST_IO_CONTROL = 8'h00;
	localparam logic [7:0] RST_MODE       = 8'h00;
	localparam logic [7:0] RST_COUNT      = 8'hff;
	localparam int         FILTER_SAMPLES = 3;
	localparam int         SUB_DIV_W      = 5;

	// --------------------------------------------------------------------
	// Encodings
	// --------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_TIMER = 3'b000,
		MODE_PULSE = 3'b001,
		MODE_EVENT = 3'b010,
		MODE_WIDTH = 3'b011
	} prtpm_mode_t;

	typedef enum logic [2:0] {
		SRC_F1   = 3'b000,
		SRC_F8   = 3'b001,
		SRC_OSC  = 3'b010,
		SRC_F2   = 3'b011,
		SRC_SUB32 = 3'b100,
		SRC_SUB  = 3'b110
	} prtpm_src_t;

	localparam logic [1:0] FILT_OFF = 2'b00;
	localparam logic [1:0] FILT_F1  = 2'b01;
	localparam logic [1:0] FILT_F8  = 2'b10;
	localparam logic [1:0] FILT_F32 = 2'b11;
	localparam logic [1:0] GATE_LOW = 2'b10;

	typedef struct packed {
		logic [1:0] eventGateSel;
		logic [1:0] inputFilterSel;
		logic       reserved;
		logic       companionOutputEnable;
		logic       ioOutputInhibit;
		logic       polaritySelect;
	} prtpm_ioctl_t;

	typedef struct packed {
		logic       sourceCutoff;
		logic [2:0] sourceSel;
		logic       reserved;
		logic [2:0] modeSel;
	} prtpm_modereg_t;

endpackage

/* File: core/prtpm_timer.sv */
/*
 * Prescaled 8-bit timer with pulse output, event counting and pulse width
 * measurement, reached over APB.
 * Assumes one 100 MHz clock; pins and foreign clocks arrive asynchronously.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module prtpm_timer (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [prtpm_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      onchipOscClock,
	input  wire logic                      subclockRaw,
	input  wire logic                      pulseIoIn,
	output logic                           pulseIoOut,
	output logic                           pulseIoOe,
	output logic                           invertedOut,
	output logic                           invertedOutEn,
	input  wire logic                      companionTimerOutput,
	output logic                           timerIrq
);
	import prtpm_pkg::*;

	// --------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------
	prtpm_ioctl_t         ioCtl_reg;
	prtpm_modereg_t       modeReg_reg;
	logic [7:0]           preCnt_reg, preReload_reg, mainCnt_reg, mainReload_reg;
	logic                 prePend_reg, mainPend_reg;
	logic                 start_reg, undf_reg, edgeFlag_reg;
	logic                 compLevel_reg, timerIrq_reg;
	logic [7:0]           prdata_reg;
	logic [3:0]           sync1_reg, sync2_reg, prevSync_reg;
	logic [4:0]           divCnt_reg;
	logic [SUB_DIV_W-1:0] subDiv_reg;
	logic [FILTER_SAMPLES-1:0] hist_reg;
	logic                 filtLevel_reg, prevFilt_reg;
	logic                 wrEn, rdSetup, mapped;
	logic                 wrCtl, wrIo, wrMode, wrPre, wrMain, forceStop;
	logic [7:0]           wByte, rByte;
	logic                 oscTick, subTick, sub32Tick, f2Tick, f8Tick, f32Tick;
	logic                 intTick, sampleEn, evTick, gateOk, inLevel, widthEnd;
	logic                 countTick, preUnderflow, mainUnderflow;
	logic                 modePulse, modeEvent, modeWidth;

	assign wByte     = pwdata[7:0];
	assign modePulse = (modeReg_reg.modeSel == MODE_PULSE);
	assign modeEvent = (modeReg_reg.modeSel == MODE_EVENT);
	assign modeWidth = (modeReg_reg.modeSel == MODE_WIDTH);

	// --------------------------------------------------------------------
	// APB slave
	// --------------------------------------------------------------------
	// Zero wait states: read data is captured in the setup phase.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = {24'h000000, prdata_reg};
	assign wrEn    = psel & penable & pwrite & pstrb[0] & mapped;
	assign rdSetup = psel & ~penable & ~pwrite;

	always_comb begin
		mapped = 1'b1;
		wrCtl  = 1'b0;
		wrIo   = 1'b0;
		wrMode = 1'b0;
		wrPre  = 1'b0;
		wrMain = 1'b0;
		rByte  = 8'h00;
		if (paddr == {IDX_CONTROL[9:0], 2'b00}) begin
			wrCtl = wrEn;
			rByte = {2'b00, undf_reg, edgeFlag_reg, 2'b00, start_reg, start_reg};
		end else if (paddr == {IDX_IO_CONTROL[9:0], 2'b00}) begin
			wrIo  = wrEn;
			rByte = ioCtl_reg;
		end else if (paddr == {IDX_MODE[9:0], 2'b00}) begin
			wrMode = wrEn;
			rByte  = modeReg_reg;
		end else if (paddr == {IDX_PRESCALER[9:0], 2'b00}) begin
			wrPre = wrEn;
			rByte = preCnt_reg;
		end else if (paddr == {IDX_MAIN_COUNT[9:0], 2'b00}) begin
			wrMain = wrEn;
			rByte = mainCnt_reg;
		end else begin
			mapped = 1'b0;
		end
	end

	assign forceStop = wrCtl & wByte[CTL_STOP_BIT];

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_reg <= 8'h00;
		end else if (rdSetup) begin
			prdata_reg <= rByte;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ioCtl_reg   <= RST_IO_CONTROL;
			modeReg_reg <= RST_MODE;
		end else begin
			if (wrIo) begin
				ioCtl_reg <= wByte;
			end
			if (wrMode) begin
				modeReg_reg <= {wByte[7:4], 1'b0, wByte[2:0]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			start_reg <= 1'b0;
		end else if (wrCtl) begin
			start_reg <= wByte[CTL_START_BIT] & ~wByte[CTL_STOP_BIT];
		end
	end

	// flags: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			undf_reg     <= 1'b0;
			edgeFlag_reg <= 1'b0;
		end else begin
			if (mainUnderflow) begin
				undf_reg <= 1'b1;
			end else if (wrCtl & ~wByte[CTL_UNDF_BIT]) begin
				undf_reg <= 1'b0;
			end
			if (widthEnd) begin
				edgeFlag_reg <= 1'b1;
			end else if (wrCtl & ~wByte[CTL_EDGE_BIT]) begin
				edgeFlag_reg <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------------
	// Input synchronisers and clock dividers
	// --------------------------------------------------------------------
	// two stages before any logic
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_reg    <= 4'h0;
			sync2_reg    <= 4'h0;
			prevSync_reg <= 4'h0;
		end else begin
			sync1_reg    <= {companionTimerOutput, subclockRaw, onchipOscClock, pulseIoIn};
			sync2_reg    <= sync1_reg;
			prevSync_reg <= sync2_reg;
		end
	end

	// Foreign clocks become one-cycle enables; they must run below half clk.
	assign oscTick   = sync2_reg[1] & ~prevSync_reg[1];
	assign subTick   = sync2_reg[2] & ~prevSync_reg[2];
	assign sub32Tick = subTick & (&subDiv_reg);
	assign f2Tick    = divCnt_reg[0];
	assign f8Tick    = &divCnt_reg[2:0];
	assign f32Tick   = &divCnt_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			divCnt_reg <= 5'h00;
			subDiv_reg <= '0;
		end else begin
			divCnt_reg <= divCnt_reg + 5'h01;
			if (subTick) begin
				subDiv_reg <= subDiv_reg + 1'b1;
			end
		end
	end

	always_comb begin
		case (modeReg_reg.sourceSel)
			SRC_F1:    intTick = 1'b1;
			SRC_F2:    intTick = f2Tick;
			SRC_F8:    intTick = f8Tick;
			SRC_OSC:   intTick = oscTick;
			SRC_SUB32: intTick = sub32Tick;
			SRC_SUB:   intTick = subTick;
			default:   intTick = 1'b0;
		endcase
	end

	// --------------------------------------------------------------------
	// Input filter and edge detection
	// --------------------------------------------------------------------
	// sampling rate
	always_comb begin
		case (ioCtl_reg.inputFilterSel)
			FILT_F1:  sampleEn = 1'b1;
			FILT_F8:  sampleEn = f8Tick;
			FILT_F32: sampleEn = f32Tick;
			default:  sampleEn = 1'b0;
		endcase
	end

	// three equal samples decide the level
	always_ff @(posedge clk) begin
		if (reset) begin
			hist_reg      <= '0;
			filtLevel_reg <= 1'b0;
			prevFilt_reg  <= 1'b0;
		end else begin
			prevFilt_reg <= filtLevel_reg;
			if (sampleEn) begin
				hist_reg <= {hist_reg[FILTER_SAMPLES-2:0], sync2_reg[0]};
			end
			if (ioCtl_reg.inputFilterSel == FILT_OFF) begin
				filtLevel_reg <= sync2_reg[0];
			end else if (&hist_reg) begin
				filtLevel_reg <= 1'b1;
			end else if (~|hist_reg) begin
				filtLevel_reg <= 1'b0;
			end
		end
	end

	// gate admits events while the companion timer output is low
	assign gateOk = (ioCtl_reg.eventGateSel != GATE_LOW) | ~sync2_reg[3];
	assign evTick = gateOk & (ioCtl_reg.polaritySelect ? (prevFilt_reg & ~filtLevel_reg)
	                                                   : (~prevFilt_reg & filtLevel_reg));
	// polarity zero measures the low level
	assign inLevel  = (filtLevel_reg == ioCtl_reg.polaritySelect);
	assign widthEnd = start_reg & modeWidth & (prevFilt_reg == ioCtl_reg.polaritySelect) &
	                  ~inLevel;

	// only the three mode codes count
	always_comb begin
		countTick = 1'b0;
		if (start_reg & ~modeReg_reg.sourceCutoff) begin
			if (modePulse) begin
				countTick = intTick;
			end else if (modeEvent) begin
				countTick = evTick;
			end else if (modeWidth) begin
				countTick = intTick & inLevel;
			end
		end
	end

	// --------------------------------------------------------------------
	// Prescaler and main counter
	// --------------------------------------------------------------------
	assign preUnderflow  = countTick & ~prePend_reg & (preCnt_reg == 8'h00);
	assign mainUnderflow = preUnderflow & ~mainPend_reg & (mainCnt_reg == 8'h00);

	always_ff @(posedge clk) begin
		if (reset | forceStop) begin
			preCnt_reg    <= RST_COUNT;
			preReload_reg <= RST_COUNT;
			prePend_reg   <= 1'b0;
		end else if (wrPre) begin
			preReload_reg <= wByte;
			// stopped writes land at once, running ones wait
			if (!start_reg) begin
				preCnt_reg  <= wByte;
				prePend_reg <= 1'b0;
			end else begin
				prePend_reg <= 1'b1;
			end
		end else if (countTick) begin
			// pending load in step with the count source
			if (prePend_reg) begin
				preCnt_reg  <= preReload_reg;
				prePend_reg <= 1'b0;
			end else if (preCnt_reg == 8'h00) begin
				preCnt_reg <= preReload_reg;
			end else begin
				preCnt_reg <= preCnt_reg - 8'h01;
			end
		end
	end

	// main counter divides prescaler underflows by m+1
	always_ff @(posedge clk) begin
		if (reset | forceStop) begin
			mainCnt_reg    <= RST_COUNT;
			mainReload_reg <= RST_COUNT;
			mainPend_reg   <= 1'b0;
		end else if (wrMain) begin
			mainReload_reg <= wByte;
			// stopped writes land at once, running ones wait
			if (!start_reg) begin
				mainCnt_reg  <= wByte;
				mainPend_reg <= 1'b0;
			end else begin
				mainPend_reg <= 1'b1;
			end
		end else if (preUnderflow) begin
			// pending load at a prescaler underflow
			if (mainPend_reg) begin
				mainCnt_reg  <= mainReload_reg;
				mainPend_reg <= 1'b0;
			end else if (mainCnt_reg == 8'h00) begin
				mainCnt_reg <= mainReload_reg;
			end else begin
				mainCnt_reg <= mainCnt_reg - 8'h01;
			end
		end
	end

	// --------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------
	// The companion level is stored; the pulse pin is its inverse.
	always_ff @(posedge clk) begin
		if (reset) begin
			compLevel_reg <= 1'b0;
		end else if (wrMode) begin
			compLevel_reg <= ioCtl_reg.polaritySelect;
		end else if (mainUnderflow & (modePulse | modeEvent)) begin
			compLevel_reg <= ~compLevel_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			timerIrq_reg <= 1'b0;
		end else begin
			timerIrq_reg <= (mainUnderflow & (modePulse | modeEvent | modeWidth)) | widthEnd;
		end
	end

	assign timerIrq   = timerIrq_reg;
	assign pulseIoOut = ~compLevel_reg;
	assign pulseIoOe  = modePulse & ~ioCtl_reg.ioOutputInhibit;
	assign invertedOut = compLevel_reg;
	assign invertedOutEn = ioCtl_reg.companionOutputEnable & (modePulse | modeEvent);

	// --------------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence seqPulseUnder;
		mainUnderflow && modePulse && !wrMode;
	endsequence

	sequence seqStoppedPreWrite;
		wrPre && !start_reg && !forceStop;
	endsequence

	chk_pulse_toggle: assert property (seqPulseUnder |=> pulseIoOut != $past(pulseIoOut))
		else $error("pulse pin did not toggle at underflow");

	chk_irq_underflow: assert property (
		mainUnderflow && (modePulse || modeEvent) |=> timerIrq && undf_reg)
		else $error("underflow raised no interrupt");

	chk_main_reload: assert property (
		mainUnderflow && !wrMain && !forceStop |=> mainCnt_reg == $past(mainReload_reg))
		else $error("main counter did not reload");

	chk_stop_halts: assert property (
		!start_reg && !wrPre && !forceStop |=> $stable(preCnt_reg))
		else $error("prescaler moved while stopped");

	chk_start_bit: assert property (
		wrCtl && wByte[CTL_START_BIT] && !wByte[CTL_STOP_BIT] |=> start_reg ##1 start_reg || wrCtl)
		else $error("start bit did not start counting");

	chk_stopped_write: assert property (
		seqStoppedPreWrite |=> preCnt_reg == $past(wByte) && preReload_reg == $past(wByte))
		else $error("stopped write did not load counter");

	chk_flag_clear: assert property (
		wrCtl && !wByte[CTL_UNDF_BIT] && !mainUnderflow |=> !undf_reg)
		else $error("underflow flag not cleared");

	chk_filter_three: assert property (
		$changed(filtLevel_reg) && $past(ioCtl_reg.inputFilterSel) != FILT_OFF
		|-> $past(hist_reg) == {FILTER_SAMPLES{filtLevel_reg}})
		else $error("filter accepted level early");

	chk_width_edge: assert property (widthEnd |=> timerIrq && edgeFlag_reg)
		else $error("width end raised no interrupt");

	chk_mode_restart: assert property (wrMode |=> invertedOut == $past(ioCtl_reg.polaritySelect))
		else $error("mode write did not restore level");

endmodule

`default_nettype wire

/* File: dv/prtpm_far_side.sv */
/*
 * Model of what stands outside the timer pins: the measured or counted
 * source, the load on the pulse pin, the companion timer and two oscillators.
 * Assumes the bench sets the wanted source level and companion level.
 */
`timescale 1ns/1ns
`default_nettype none

module prtpm_far_side (
	input  wire logic srcLevel,
	input  wire logic gateHigh,
	input  wire logic pulseIoOut,
	input  wire logic pulseIoOe,
	output logic      pulseIoIn,
	output logic      companionTimerOutput,
	output var logic  onchipOscClock,
	output var logic  subclockRaw
);
	// -------------------------------------------------------------------
	// Pin resolution
	// -------------------------------------------------------------------
	// The timer's own drive wins on the shared pin, so pulse mode reads back its output unless ioOutputInhibit is set.
	assign pulseIoIn = pulseIoOe ? pulseIoOut : srcLevel;
	assign companionTimerOutput = gateHigh;

	// -------------------------------------------------------------------
	// Free-running oscillators
	// -------------------------------------------------------------------
	// The offset keeps their edges clear of the main clock edges.
	initial begin
		onchipOscClock = 1'b0;
		subclockRaw = 1'b0;
		#3;
		fork
			forever #25 onchipOscClock = ~onchipOscClock;
			forever #35 subclockRaw = ~subclockRaw;
		join
	end
endmodule
`default_nettype wire

/* File: dv/tb_prtpm_timer.sv */
/*
 * Self-checking bench of the prescaled pulse timer over APB.
 * Assumes the far-side model for pins and a zero-wait APB slave.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_prtpm_timer;
	import prtpm_pkg::*;

	localparam logic [11:0] A_CTL  = {IDX_CONTROL[9:0], 2'b00};
	localparam logic [11:0] A_IO   = {IDX_IO_CONTROL[9:0], 2'b00};
	localparam logic [11:0] A_MODE = {IDX_MODE[9:0], 2'b00};
	localparam logic [11:0] A_PRE  = {IDX_PRESCALER[9:0], 2'b00};
	localparam logic [11:0] A_MAIN = {IDX_MAIN_COUNT[9:0], 2'b00};

	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready, pslverr, pulseIoIn, pulseIoOut, pulseIoOe;
	logic        invertedOut, invertedOutEn, companionTimerOutput, timerIrq;
	logic        onchipOscClock, subclockRaw;
	logic        srcLevel = 1'b0;
	logic        gateHigh = 1'b0;
	logic [7:0]  rdata, m;
	logic        lastErr, lvl;
	int          num_errors = 0;
	int          comparisons = 0;
	int          irqCount = 0;
	int          c, n;
	logic [7:0]  modes [6] = '{8'h01, 8'h31, 8'h11, 8'h21, 8'h41, 8'h61};
	int          periods [6] = '{20, 40, 160, 100, 4480, 140};

	always #5 clk = ~clk;
	always @(posedge clk) if (timerIrq === 1'b1) irqCount <= irqCount + 1;

	prtpm_timer dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.onchipOscClock(onchipOscClock), .subclockRaw(subclockRaw),
		.pulseIoIn(pulseIoIn), .pulseIoOut(pulseIoOut), .pulseIoOe(pulseIoOe),
		.invertedOut(invertedOut), .invertedOutEn(invertedOutEn),
		.companionTimerOutput(companionTimerOutput), .timerIrq(timerIrq));

	prtpm_far_side far (.srcLevel(srcLevel), .gateHigh(gateHigh),
		.pulseIoOut(pulseIoOut), .pulseIoOe(pulseIoOe), .pulseIoIn(pulseIoIn),
		.companionTimerOutput(companionTimerOutput),
		.onchipOscClock(onchipOscClock), .subclockRaw(subclockRaw));

	// -------------------------------------------------------------------
	// Bus and check tasks
	// -------------------------------------------------------------------
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int w;
		w = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && w < 16) begin
			@(posedge clk);
			w++;
		end
		rdata = prdata[7:0];
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task rc(input string name, input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		check(name, {8'h0, rdata}, {8'h0, exp});
	endtask

	// Cycles between two successive interrupt pulses.
	task period(output int p);
		int w;
		w = 0;
		@(negedge clk);
		while (timerIrq !== 1'b1 && w < 6000) begin
			@(negedge clk);
			w++;
		end
		p = 0;
		@(negedge clk);
		while (timerIrq !== 1'b1 && p < 6000) begin
			@(negedge clk);
			p++;
		end
		p++;
	endtask

	task pulses(input int k);
		repeat (k) begin
			@(posedge clk) srcLevel <= 1'b1;
			repeat (8) @(posedge clk);
			srcLevel <= 1'b0;
			repeat (8) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask

	task final_report;
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		final_report;
	end

	// -------------------------------------------------------------------
	// Test sequence
	// -------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rc("ioReset", A_IO, RST_IO_CONTROL);
		rc("modeReset", A_MODE, RST_MODE);
		rc("preReset", A_PRE, RST_COUNT);
		rc("mainReset", A_MAIN, RST_COUNT);
		rc("ctlReset", A_CTL, 8'h00);
		apb(1'b0, 12'h414, 8'h00);
		check("unmappedErr", {15'h0, lastErr}, 16'h1);
		wr(A_PRE, 8'h03);
		wr(A_MAIN, 8'h04);
		rc("preLoad", A_PRE, 8'h03); // stopped load
		rc("mainLoad", A_MAIN, 8'h04); // live read
		wr(A_IO, 8'h04); // companion output enable
		for (int k = 0; k < 6; k++) begin
			wr(A_CTL, 8'h00);
			wr(A_MODE, modes[k]);
			@(negedge clk);
			check("startHigh", {15'h0, pulseIoOut}, 16'h1); // start level
			check("restart", {15'h0, invertedOut}, 16'h0); // level on mode write
			check("pinDriven", {15'h0, pulseIoOe}, 16'h1); // output drive
			check("compEn", {15'h0, invertedOutEn}, 16'h1); // companion enable
			wr(A_CTL, 8'h01);
			period(n);
			check("period", n[15:0], periods[k][15:0]); // source and ratio
		end
		// Two interrupts toggle the pin twice, so the level is taken after them.
		period(n);
		lvl = pulseIoOut;
		@(posedge timerIrq);
		@(negedge clk);
		check("toggle", {15'h0, pulseIoOut}, {15'h0, ~lvl}); // pin toggles
		check("inverse", {15'h0, invertedOut}, {15'h0, ~pulseIoOut}); // inverted copy
		rc("ctlRun", A_CTL, 8'h23); // underflow flag
		wr(A_CTL, 8'h20);
		rc("flagKept", A_CTL, 8'h20); // write one keeps flag
		apb(1'b0, A_MAIN, 8'h00);
		m = rdata;
		repeat (300) @(posedge clk);
		rc("halted", A_MAIN, m); // stop holds count
		wr(A_CTL, 8'h00);
		rc("flagClr", A_CTL, 8'h00); // write zero clears
		wr(A_PRE, 8'hff);
		wr(A_MAIN, 8'h04);
		wr(A_CTL, 8'h01);
		wr(A_MAIN, 8'h02);
		rc("deferred", A_MAIN, 8'h04); // deferred load
		wr(A_CTL, 8'h04);
		rc("fstopCtl", A_CTL, 8'h00); // forced stop
		rc("fstopPre", A_PRE, 8'hff); // forced stop
		rc("fstopMain", A_MAIN, 8'hff); // forced stop
		wr(A_IO, 8'h05);
		wr(A_MODE, 8'h01);
		@(negedge clk);
		check("startLow", {15'h0, pulseIoOut}, 16'h0); // start level
		wr(A_IO, 8'h07);
		@(negedge clk);
		check("inhibit", {15'h0, pulseIoOe}, 16'h0); // output disabled
		wr(A_PRE, 8'h00);
		wr(A_MAIN, 8'h01);
		wr(A_IO, 8'h04);
		wr(A_MODE, 8'h02);
		@(negedge clk);
		check("evStartLow", {15'h0, invertedOut}, 16'h0); // companion start
		wr(A_CTL, 8'h01);
		c = irqCount;
		pulses(2);
		check("evToggle", {15'h0, invertedOut}, 16'h1); // companion toggle
		pulses(2);
		check("evCount", 16'(irqCount - c), 16'h2); // rising edges
		wr(A_IO, 8'h84);
		gateHigh <= 1'b1;
		c = irqCount;
		pulses(2);
		check("gateShut", 16'(irqCount - c), 16'h0); // gate closed
		gateHigh <= 1'b0;
		pulses(2);
		check("gateOpen", 16'(irqCount - c), 16'h1); // gate open
		wr(A_CTL, 8'h00);
		wr(A_IO, 8'h15);
		wr(A_MODE, 8'h02);
		@(negedge clk);
		check("evStartHigh", {15'h0, invertedOut}, 16'h1); // companion start
		wr(A_CTL, 8'h01);
		c = irqCount;
		@(posedge clk) srcLevel <= 1'b1;
		repeat (2) @(posedge clk);
		srcLevel <= 1'b0;
		pulses(2);
		check("filtered", 16'(irqCount - c), 16'h1); // glitch rejected
		wr(A_CTL, 8'h00);
		wr(A_PRE, 8'h00);
		wr(A_MAIN, 8'h80);
		wr(A_IO, 8'h01);
		wr(A_MODE, 8'h03);
		wr(A_CTL, 8'h01);
		c = irqCount;
		@(posedge clk) srcLevel <= 1'b1;
		repeat (16) @(posedge clk);
		srcLevel <= 1'b0;
		repeat (10) @(posedge clk);
		rc("edgeFlag", A_CTL, 8'h13); // end of period flag
		check("edgeIrq", 16'(irqCount - c), 16'h1); // end interrupt
		apb(1'b0, A_MAIN, 8'h00);
		m = rdata;
		check("widthCnt", {15'h0, m < 8'h80 && m > 8'h60}, 16'h1); // counts high
		repeat (50) @(posedge clk);
		rc("widthHold", A_MAIN, m); // idle while low
		final_report;
	end
endmodule
`default_nettype wire
